//--- rtl/hfc_top.sv
`default_nettype none
module hfc_top
	import hfc_pkg::*;
#(
	parameter int STEP_CYCLES = HFC_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire hfc_reg_req_t host_req,
	output logic [7:0] host_rdata,
	input wire hfc_reg_req_t eep_req,
	input wire logic smbus_select_n,
	input wire logic power_enable_polarity,
	input wire logic config_mode_active,
	input wire logic [HFC_DLY_W-1:0] fused_power_restore_delay,
	input wire hfc_status_t link_status,
	output hfc_status_t status_pins_out,
	output logic [HFC_NSTS-1:0] status_pins_oe,
	output logic ss_spread_disable,
	input wire logic [HFC_NPORTS-1:0] port_power_request,
	input wire logic [HFC_NPORTS-1:0] port_charge_mode_change,
	output logic [HFC_NPORTS-1:0] port_power_enable_out,
	output logic config_in_progress,
	output logic upstream_connect_hold
);
	//////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic smbus_select_n_s;
	logic polarity_s;

	hfc_pin_sync #(
		.W(1),
		.RST_VAL(1'b1)
	) u_sync_mode (
		.clk(clk),
		.nrst(nrst),
		.pin_in(smbus_select_n),
		.pin_sync(smbus_select_n_s)
	);

	// reset value matches pulled up pin
	hfc_pin_sync #(
		.W(1),
		.RST_VAL(1'b1)
	) u_sync_pol (
		.clk(clk),
		.nrst(nrst),
		.pin_in(power_enable_polarity),
		.pin_sync(polarity_s)
	);

	logic smbus_mode;
	assign smbus_mode = !smbus_select_n_s;

	//////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] feature_ff, nxt_feature;
	logic soft_rst_ff, nxt_soft_rst;
	logic cfg_ff, nxt_cfg;
	logic cfg_mode_d_ff, nxt_cfg_mode_d;
	logic [7:0] rdata_ff, nxt_rdata;
	logic host_wr_feat, eep_wr_feat, host_wr_cmd;
	logic mode_enter, mode_exit;

	always_comb begin
		host_wr_feat = host_req.wr && (host_req.addr == HFC_OFS_FEATURE);
		eep_wr_feat = eep_req.wr && (eep_req.addr == HFC_OFS_FEATURE);
		host_wr_cmd = host_req.wr && (host_req.addr == HFC_OFS_HOSTCMD);
		mode_enter = config_mode_active && !cfg_mode_d_ff;
		mode_exit = !config_mode_active && cfg_mode_d_ff;
		nxt_cfg_mode_d = config_mode_active;
		nxt_feature = feature_ff;
		nxt_soft_rst = 1'b0;
		nxt_cfg = cfg_ff;
		nxt_rdata = rdata_ff;
		if (soft_rst_ff) begin
			nxt_feature = HFC_FEATURE_RST;
			nxt_cfg = 1'b1;
		end else begin
			if (host_wr_feat) begin
				nxt_feature = host_req.wdata;
			end else if (eep_wr_feat) begin
				nxt_feature = eep_req.wdata;
			end
			// set by writing 1 in smbus mode
			if (host_wr_cmd && smbus_mode && host_req.wdata[HFC_BIT_SOFT_RST]) begin
				nxt_soft_rst = 1'b1;
			end
			if (host_wr_cmd && host_req.wdata[HFC_BIT_CFG]) begin
				nxt_cfg = 1'b0;
			end
			if (mode_exit && !smbus_mode) begin
				nxt_cfg = 1'b0;
			end
			// mode entry sets flag, wins over clear
			if (mode_enter) begin
				nxt_cfg = 1'b1;
			end
		end
		if (host_req.rd) begin
			unique case (host_req.addr)
				HFC_OFS_FEATURE: nxt_rdata = feature_ff;
				HFC_OFS_HOSTCMD: nxt_rdata = {6'h00, soft_rst_ff, cfg_ff};
				default: nxt_rdata = HFC_ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			feature_ff <= HFC_FEATURE_RST;
			soft_rst_ff <= 1'b0;
			cfg_ff <= 1'b0;
			cfg_mode_d_ff <= 1'b0;
			rdata_ff <= HFC_ZERO_BYTE;
		end else begin
			feature_ff <= nxt_feature;
			soft_rst_ff <= nxt_soft_rst;
			cfg_ff <= nxt_cfg;
			cfg_mode_d_ff <= nxt_cfg_mode_d;
			rdata_ff <= nxt_rdata;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// status pins, spread spectrum, upstream hold
	hfc_status_t sts_ff, nxt_sts;
	logic [HFC_NSTS-1:0] sts_oe_ff, nxt_sts_oe;
	logic spread_ff, nxt_spread;
	logic hold_ff, nxt_hold;

	always_comb begin
		// status outputs gated by enable bit
		nxt_sts_oe = feature_ff[HFC_BIT_STS_EN] ? {HFC_NSTS{1'b1}} : HFC_STS_OFF;
		nxt_sts = feature_ff[HFC_BIT_STS_EN] ? link_status : hfc_status_t'(HFC_STS_OFF);
		nxt_spread = feature_ff[HFC_BIT_SPREAD];
		nxt_hold = nxt_cfg;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			sts_ff <= hfc_status_t'(HFC_STS_OFF);
			sts_oe_ff <= HFC_STS_OFF;
			spread_ff <= 1'b0;
			hold_ff <= 1'b0;
		end else begin
			sts_ff <= nxt_sts;
			sts_oe_ff <= nxt_sts_oe;
			spread_ff <= nxt_spread;
			hold_ff <= nxt_hold;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// port power restore
	logic [HFC_DLY_W-1:0] delay_steps;
	logic [HFC_NPORTS-1:0] timer_busy;
	logic [HFC_NPORTS-1:0] port_on;
	logic [HFC_NPORTS-1:0] pwr_out_ff, nxt_pwr_out;

	assign delay_steps = (fused_power_restore_delay != HFC_DLY_ZERO) ?
		fused_power_restore_delay : feature_ff[HFC_DLY_MSB:HFC_DLY_LSB];

	genvar gp;
	generate
		for (gp = 0; gp < HFC_NPORTS; gp++) begin : g_port
			hfc_restore_timer #(
				.STEP_CYCLES(STEP_CYCLES)
			) u_timer (
				.clk(clk),
				.nrst(nrst),
				.start(port_charge_mode_change[gp]),
				.delay_steps(delay_steps),
				.busy(timer_busy[gp])
			);
		end
	endgenerate

	always_comb begin
		port_on = port_power_request & ~timer_busy;
		nxt_pwr_out = polarity_s ? port_on : ~port_on;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			pwr_out_ff <= ~HFC_PORTS_OFF;
		end else begin
			pwr_out_ff <= nxt_pwr_out;
		end
	end

	assign host_rdata = rdata_ff;
	assign status_pins_out = sts_ff;
	assign status_pins_oe = sts_oe_ff;
	assign ss_spread_disable = spread_ff;
	assign port_power_enable_out = pwr_out_ff;
	assign config_in_progress = cfg_ff;
	assign upstream_connect_hold = hold_ff;

	//////////////////////////////////////////////////////////////////////
	// checks
	chk_sts_pin_enable: assert property (
		@(posedge clk) disable iff (!nrst)
		(host_wr_feat && !soft_rst_ff) |-> ##2
			(status_pins_oe == {HFC_NSTS{$past(host_req.wdata[HFC_BIT_STS_EN], 2)}})
	) else $error("status pin enable does not follow written bit");

	chk_spread_bit: assert property (
		@(posedge clk) disable iff (!nrst)
		(host_wr_feat && !soft_rst_ff) |-> ##2
			(ss_spread_disable == $past(host_req.wdata[HFC_BIT_SPREAD], 2))
	) else $error("spread disable does not follow written bit");

	chk_eep_load: assert property (
		@(posedge clk) disable iff (!nrst)
		(eep_wr_feat && !host_wr_feat && !soft_rst_ff) |=>
			(feature_ff == $past(eep_req.wdata))
	) else $error("eeprom load not taken");

	chk_rsvd_zero: assert property (
		@(posedge clk) disable iff (!nrst)
		(host_req.rd && host_req.addr == HFC_OFS_HOSTCMD) |=> (host_rdata[7:2] == 6'h00)
	) else $error("reserved command bits not zero");

	chk_soft_reset: assert property (
		@(posedge clk) disable iff (!nrst)
		soft_rst_ff |=> (feature_ff == HFC_FEATURE_RST) && cfg_ff && !soft_rst_ff
	) else $error("soft reset did not restore registers");

	chk_soft_set: assert property (
		@(posedge clk) disable iff (!nrst)
		(!soft_rst_ff && host_wr_cmd && !smbus_mode) |=> !soft_rst_ff
	) else $error("soft reset set outside smbus mode");

	chk_flag_enter: assert property (
		@(posedge clk) disable iff (!nrst)
		$rose(config_mode_active) |=> config_in_progress && upstream_connect_hold
	) else $error("config flag not set on mode entry");

	chk_flag_hold: assert property (
		@(posedge clk) disable iff (!nrst)
		config_in_progress |-> upstream_connect_hold
	) else $error("upstream not held while configuring");

	chk_i2c_exit: assert property (
		@(posedge clk) disable iff (!nrst)
		(mode_exit && !smbus_mode && !soft_rst_ff) |=> !cfg_ff
	) else $error("flag not cleared on i2c exit");

	chk_write0_keep: assert property (
		@(posedge clk) disable iff (!nrst)
		(cfg_ff && host_wr_cmd && !host_req.wdata[HFC_BIT_CFG] && !mode_exit) |=> cfg_ff
	) else $error("writing zero changed config flag");

	chk_pwr_drop: assert property (
		@(posedge clk) disable iff (!nrst)
		(port_charge_mode_change[0] && polarity_s) ##1 polarity_s |=>
			!port_power_enable_out[0]
	) else $error("port power not removed on mode change");

	chk_polarity: assert property (
		@(posedge clk) disable iff (!nrst)
		1'b1 |=> (port_power_enable_out ==
			($past(polarity_s) ? $past(port_on) : ~$past(port_on)))
	) else $error("power enable polarity wrong");
endmodule
`default_nettype wire

//--- rtl/hfc_pkg.sv
`default_nettype none
package hfc_pkg;
	localparam logic [7:0] HFC_OFS_FEATURE = 8'hf0;
	localparam logic [7:0] HFC_OFS_HOSTCMD = 8'hf8;
	localparam logic [7:0] HFC_FEATURE_RST = 8'h00;
	localparam logic [7:0] HFC_ZERO_BYTE = 8'h00;
	localparam int HFC_BIT_RSVD_LSB = 5;
	localparam int HFC_BIT_RSVD_MSB = 7;
	localparam int HFC_BIT_STS_EN = 4;
	localparam int HFC_DLY_MSB = 3;
	localparam int HFC_DLY_LSB = 1;
	localparam int HFC_BIT_SPREAD = 0;
	localparam int HFC_BIT_SOFT_RST = 1;
	localparam int HFC_BIT_CFG = 0;
	localparam int HFC_DLY_W = 3;
	localparam int HFC_NPORTS = 4;
	localparam int HFC_NSTS = 4;
	localparam int HFC_CNT_W = 25;
	localparam logic [HFC_DLY_W-1:0] HFC_DLY_ZERO = 3'h0;
	localparam logic [HFC_NPORTS-1:0] HFC_PORTS_OFF = 4'h0;
	localparam logic [HFC_NSTS-1:0] HFC_STS_OFF = 4'h0;
	// one power restore step in ms, and the clock in kHz
	localparam int HFC_STEP_MS = 200;
	localparam int HFC_CLK_KHZ = 100_000;
	localparam int HFC_STEP_CYCLES = HFC_STEP_MS * HFC_CLK_KHZ;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} hfc_reg_req_t;

	typedef struct packed {
		logic hs_link_up_out;
		logic hs_suspended_out;
		logic ss_link_up_out;
		logic ss_suspended_out;
	} hfc_status_t;
endpackage
`default_nettype wire

//--- rtl/hfc_pin_sync.sv
`default_nettype none
module hfc_pin_sync
	import hfc_pkg::*;
#(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_sync
);
	logic [W-1:0] stage1_ff;
	logic [W-1:0] stage2_ff;
	logic [W-1:0] nxt_stage1;
	logic [W-1:0] nxt_stage2;

	always_comb begin
		nxt_stage1 = pin_in;
		nxt_stage2 = stage1_ff;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			stage1_ff <= RST_VAL;
			stage2_ff <= RST_VAL;
		end else begin
			stage1_ff <= nxt_stage1;
			stage2_ff <= nxt_stage2;
		end
	end

	assign pin_sync = stage2_ff;
endmodule
`default_nettype wire

//--- rtl/hfc_restore_timer.sv
`default_nettype none
module hfc_restore_timer
	import hfc_pkg::*;
#(
	parameter int STEP_CYCLES = HFC_STEP_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic [HFC_DLY_W-1:0] delay_steps,
	output logic busy
);
	localparam logic [HFC_CNT_W-1:0] STEP_LAST = HFC_CNT_W'(STEP_CYCLES - 1);
	localparam logic [HFC_CNT_W-1:0] CNT_ONE = 25'h000_0001;

	logic busy_ff, nxt_busy;
	logic [HFC_DLY_W-1:0] steps_ff, nxt_steps;
	logic [HFC_DLY_W-1:0] step_cnt_ff, nxt_step_cnt;
	logic [HFC_CNT_W-1:0] cyc_ff, nxt_cyc;
	logic step_tick;

	//////////////////////////////////////////////////////////////////////
	// reference clock counter
	always_comb begin
		step_tick = (cyc_ff == STEP_LAST);
		nxt_busy = busy_ff;
		nxt_steps = steps_ff;
		nxt_step_cnt = step_cnt_ff;
		nxt_cyc = cyc_ff;
		if (start) begin
			nxt_busy = 1'b1;
			nxt_steps = delay_steps;
			nxt_step_cnt = HFC_DLY_ZERO;
			nxt_cyc = '0;
		end else if (busy_ff) begin
			if (step_cnt_ff == steps_ff) begin
				nxt_busy = 1'b0;
			end else if (step_tick) begin
				nxt_cyc = '0;
				nxt_step_cnt = step_cnt_ff + HFC_DLY_W'(1);
			end else begin
				nxt_cyc = cyc_ff + CNT_ONE;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			busy_ff <= 1'b0;
			steps_ff <= HFC_DLY_ZERO;
			step_cnt_ff <= HFC_DLY_ZERO;
			cyc_ff <= '0;
		end else begin
			busy_ff <= nxt_busy;
			steps_ff <= nxt_steps;
			step_cnt_ff <= nxt_step_cnt;
			cyc_ff <= nxt_cyc;
		end
	end

	assign busy = busy_ff;

	//////////////////////////////////////////////////////////////////////
	// checks: busy cycle count against programmed steps
	int busy_len_ff;
	always_ff @(posedge clk) begin
		if (!nrst || start) begin
			busy_len_ff <= 0;
		end else if (busy_ff) begin
			busy_len_ff <= busy_len_ff + 1;
		end
	end

	chk_delay_length: assert property (
		@(posedge clk) disable iff (!nrst)
		($fell(busy_ff) && !$past(start)) |->
			(busy_len_ff == int'(steps_ff) * STEP_CYCLES + 1)
	) else $error("power restore delay length wrong");
endmodule
`default_nettype wire

//--- verif/hfc_host_model.sv
`default_nettype none
module hfc_host_model
	import hfc_pkg::*;
(
	input wire logic clk,
	input wire logic [7:0] rdata,
	output var hfc_reg_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial req = '0;

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
		@(posedge clk);
		req <= '0;
		@(posedge clk);
		#1 d = rdata;
		@(posedge clk);
	endtask
endmodule
`default_nettype wire

//--- verif/tb.sv
`default_nettype none
module tb
	import hfc_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk;
	logic nrst;
	logic smb_n;
	logic pol;
	logic cfg;
	logic [2:0] fused;
	logic [3:0] req_p;
	logic [3:0] chg;
	hfc_status_t lst;
	hfc_reg_req_t host_req;
	hfc_reg_req_t eep;
	logic [7:0] rdata;
	hfc_status_t sts;
	logic [3:0] oe;
	logic spread;
	logic [3:0] pwr;
	logic flag;
	logic hold;
	logic [7:0] d;
	int n_mismatch = 0;
	int cmp_count = 0;

	hfc_top #(.STEP_CYCLES(10)) hfc_top_i (
		.clk(clk),
		.nrst(nrst),
		.host_req(host_req),
		.host_rdata(rdata),
		.eep_req(eep),
		.smbus_select_n(smb_n),
		.power_enable_polarity(pol),
		.config_mode_active(cfg),
		.fused_power_restore_delay(fused),
		.link_status(lst),
		.status_pins_out(sts),
		.status_pins_oe(oe),
		.ss_spread_disable(spread),
		.port_power_request(req_p),
		.port_charge_mode_change(chg),
		.port_power_enable_out(pwr),
		.config_in_progress(flag),
		.upstream_connect_hold(hold)
	);

	hfc_host_model hfc_host_model_i (
		.clk(clk),
		.rdata(rdata),
		.req(host_req)
	);

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic report_and_stop;
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		settle(0);
		chk({4'h0, pwr}, 8'h0f);
		chk({6'h0, hold, flag}, 8'h00);
		@(posedge clk);
		hfc_host_model_i.rd(HFC_OFS_FEATURE, d);
		chk(d, 8'h00);
	endtask

	task automatic t_feat;
		lst <= 4'ha;
		hfc_host_model_i.wr(HFC_OFS_FEATURE, 8'h11);
		settle(2);
		chk({oe, sts}, 8'hfa);
		chk({7'h0, spread}, 8'h01);
		@(posedge clk);
		eep <= '{rd: 1'b0, wr: 1'b1, addr: HFC_OFS_FEATURE, wdata: 8'h00};
		@(posedge clk);
		eep <= '0;
		settle(3);
		chk({oe, sts}, 8'h00);
		chk({7'h0, spread}, 8'h00);
		@(posedge clk);
	endtask

	// off time is steps * 10 + 1 cycles, other ports untouched
	task automatic t_restore(input logic [2:0] fz, input logic [7:0] ft, input int exp);
		int n;
		n = 0;
		fused <= fz;
		hfc_host_model_i.wr(HFC_OFS_FEATURE, ft);
		chg <= 4'h1;
		@(posedge clk);
		chg <= 4'h0;
		repeat (85) begin
			@(negedge clk);
			if (pwr[0] === 1'b0) n++;
			if (pwr[3:1] !== 3'h7) n += 100;
		end
		@(posedge clk);
		chk(8'(n), 8'(exp));
	endtask

	task automatic t_pol;
		pol <= 1'b0;
		req_p <= 4'h5;
		settle(4);
		chk({4'h0, pwr}, 8'h0a);
		@(posedge clk);
		pol <= 1'b1;
		settle(4);
		chk({4'h0, pwr}, 8'h05);
		@(posedge clk);
		req_p <= 4'hf;
	endtask

	task automatic t_cfg;
		cfg <= 1'b1;
		settle(2);
		chk({6'h0, hold, flag}, 8'h03);
		@(posedge clk);
		hfc_host_model_i.wr(HFC_OFS_HOSTCMD, 8'h00);
		hfc_host_model_i.rd(HFC_OFS_HOSTCMD, d);
		chk(d, 8'h01);
		hfc_host_model_i.wr(HFC_OFS_HOSTCMD, 8'hfd);
		hfc_host_model_i.rd(HFC_OFS_HOSTCMD, d);
		chk(d, 8'h00);
		chk({6'h0, hold, flag}, 8'h00);
	endtask

	task automatic t_srst;
		hfc_host_model_i.wr(HFC_OFS_FEATURE, 8'h15);
		hfc_host_model_i.wr(HFC_OFS_HOSTCMD, 8'h02);
		hfc_host_model_i.rd(HFC_OFS_FEATURE, d);
		chk(d, 8'h00);
		hfc_host_model_i.rd(HFC_OFS_HOSTCMD, d);
		chk(d, 8'h01);
		hfc_host_model_i.wr(HFC_OFS_HOSTCMD, 8'h01);
		smb_n <= 1'b1;
		repeat (3) @(posedge clk);
		hfc_host_model_i.wr(HFC_OFS_FEATURE, 8'h15);
		hfc_host_model_i.wr(HFC_OFS_HOSTCMD, 8'h02);
		hfc_host_model_i.wr(8'h20, 8'h5a);
		hfc_host_model_i.rd(HFC_OFS_FEATURE, d);
		chk(d, 8'h15);
		hfc_host_model_i.rd(HFC_OFS_HOSTCMD, d);
		chk(d, 8'h00);
		hfc_host_model_i.rd(8'h20, d);
		chk(d, 8'h00);
	endtask

	task automatic t_i2c;
		cfg <= 1'b0;
		repeat (2) @(posedge clk);
		cfg <= 1'b1;
		settle(2);
		chk({7'h0, flag}, 8'h01);
		@(posedge clk);
		cfg <= 1'b0;
		settle(2);
		chk({6'h0, hold, flag}, 8'h00);
		@(posedge clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		report_and_stop;
	end

	initial begin
		nrst = 1'b0;
		smb_n = 1'b0;
		pol = 1'b1;
		cfg = 1'b0;
		fused = 3'h0;
		req_p = 4'hf;
		chg = 4'h0;
		lst = 4'h0;
		eep = '0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_reset;
		t_feat;
		t_restore(3'h0, 8'h0e, 71);
		t_restore(3'h1, 8'h0e, 11);
		t_restore(3'h0, 8'h00, 1);
		t_pol;
		t_cfg;
		t_srst;
		t_i2c;
		report_and_stop;
	end
endmodule
`default_nettype wire
